// [hdl/clk_div_stage.sv]
`timescale 1ns/10ps
module clk_div_stage #(
	parameter int W = 4
) (
	// Clock and reset
	input wire logic clk_i,
	input wire logic sys_rst_i,
	// Source level and its rising edge
	input wire logic src_i,
	input wire logic rise_i,
	input wire logic [W-1:0] setup_i,
	// Divided clock level
	output logic clk_o
);

	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (sys_rst_i);

	if (W < 1 || W > 16) begin : g_chk
		$error("clk_div_stage: W out of range");
	end

	logic [W-1:0] cnt_q, cnt_d;
	logic [W:0] half;
	logic out_d;

	// Count source rises; high phase is the shorter one on odd ratios
	always_comb begin
		cnt_d = cnt_q;
		out_d = clk_o;
		half = ({1'b0, setup_i} + (W+1)'(2)) >> 1;
		if (setup_i == '0) begin
			cnt_d = '0;
			out_d = src_i; // Ratio one passes through
		end else if (rise_i) begin
			cnt_d = (cnt_q >= setup_i) ? '0 : cnt_q + W'(1);
			out_d = ({1'b0, cnt_d} >= half);
		end
	end

	always_ff @(posedge clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			cnt_q <= '0;
			clk_o <= 1'b0;
		end else begin
			cnt_q <= cnt_d;
			clk_o <= out_d;
		end
	end

	pass_thru_a: assert property (setup_i == '0 |=> clk_o == $past(src_i))
		else $error("divider bypass does not follow source");
	wrap_a: assert property (setup_i != '0 && $stable(setup_i) && rise_i
		&& cnt_q == setup_i |=> cnt_q == '0)
		else $error("divider does not wrap after setup plus one");
	duty_a: assert property ($past(rise_i) && $stable(setup_i)
		&& setup_i != '0 |-> clk_o == ({1'b0, cnt_q} >= half))
		else $error("divider high phase misplaced");
	div3_c: cover property (setup_i == W'(2) && $rose(clk_o));

endmodule

// [hdl/clock_unit_gating_divider.sv]
// What this block does
// - Gate bits 0-10 open the eleven module clocks in fixed order.
// - Master and pixel clocks pick one of four inputs, optionally via PLL.
// - Scaler video clock only feeds the video interface gate.
// - All module clock gates are closed after hardware reset.
// - Synchronised reset goes to all components, needs crystal clock.
// - Reset stays asserted while the crystal input does not toggle.
// - Dividers divide by setup value plus one, zero passes through.
// - Odd ratios give a high phase one cycle shorter than low.
// - Global reset bit reads zero; write one asserts, zero releases.
// - PLL lock bit is read only; writes do nothing.
//
// The address map and strobed register access were left to the implementer.
`timescale 1ns/10ps
module clock_unit_gating_divider
	import clock_unit_pkg::*;
#(
	parameter int XTAL_TIMEOUT = XTAL_TO
) (
	// Clock and reset
	input wire logic clk_i,
	input wire logic sys_rst_i,
	// Register port
	input wire logic [7:0] reg_addr_i,
	input wire logic [31:0] reg_wdata_i,
	input wire logic reg_wr_i,
	input wire logic reg_rd_i,
	output logic [31:0] reg_rdata_o,
	// Clock and reset pins
	input wire logic crystal_input_i,
	input wire logic display_pixel_clock_input_i,
	input wire logic host_bus_clock_i,
	input wire logic aux_ref_clock_i,
	input wire logic scaler_video_clock_i,
	input wire logic external_reset_n_i,
	// Analog PLL macro
	input wire logic pll_clk_i,
	input wire logic pll_lock_i,
	output logic pll_ref_o,
	output logic pll_powerdown_o,
	// Generated clocks and reset
	output logic master_clk_o,
	output logic pixel_clk_o,
	output logic [GATE_N-1:0] gate_clk_o,
	output logic core_rst_o
);

	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (sys_rst_i);

	if (XTAL_TIMEOUT < 2 || XTAL_TIMEOUT >= 2**XWD_W) begin : g_chk
		$error("XTAL_TIMEOUT out of range");
	end

	localparam logic [XWD_W-1:0] XWD_MAX = XWD_W'(XTAL_TIMEOUT);

	// Level of one selectable input; scaler clock is not offered
	function automatic logic src_lvl(clk_src_t s, logic use_pll, pins_t p);
		src_lvl = p.pll_clk;
		if (!use_pll) begin
			case (s)
				SRC_XTAL: src_lvl = p.xtal;
				SRC_PIXIN: src_lvl = p.pixin;
				SRC_HOST: src_lvl = p.host;
				default: src_lvl = p.aux;
			endcase
		end
	endfunction

	pins_t pin_raw, sync1_q, sync2_q, sync3_q;

	// Pins cross into clk_i; third stage only feeds edge detection
	always_comb begin
		pin_raw = '{pll_lock: pll_lock_i, pll_clk: pll_clk_i,
			ext_rst_n: external_reset_n_i, scaler: scaler_video_clock_i,
			aux: aux_ref_clock_i, host: host_bus_clock_i,
			pixin: display_pixel_clock_input_i, xtal: crystal_input_i};
	end

	always_ff @(posedge clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			sync1_q <= '0;
			sync2_q <= '0;
			sync3_q <= '0;
		end else begin
			sync1_q <= pin_raw;
			sync2_q <= sync1_q;
			sync3_q <= sync2_q;
		end
	end

	// Register state
	routing_t route_q, route_d;
	logic [GATE_N-1:0] en_q, en_d;
	logic run_q, run_d;
	logic srst_q, srst_d;
	logic [31:0] rdata_d;

	// Decode writes and reads; lock bit is not stored, reset bit is stored but never read back
	always_comb begin
		route_d = route_q;
		en_d = en_q;
		run_d = run_q;
		srst_d = srst_q;
		rdata_d = '0;
		if (reg_wr_i) begin
			if (reg_addr_i == ROUTE_ADDR) begin
				route_d = routing_t'(reg_wdata_i[ROUTE_W-1:0]);
			end else if (reg_addr_i == GATE_ADDR) begin
				en_d = reg_wdata_i[GATE_N-1:0];
				run_d = reg_wdata_i[RUN_BIT];
				srst_d = reg_wdata_i[GRST_BIT];
			end
		end
		if (reg_rd_i) begin
			if (reg_addr_i == ROUTE_ADDR) begin
				rdata_d[ROUTE_W-1:0] = route_q;
			end else if (reg_addr_i == GATE_ADDR) begin
				rdata_d[GATE_N-1:0] = en_q;
				rdata_d[RUN_BIT] = run_q;
				// Lock only means anything while the PLL runs
				rdata_d[LOCK_BIT] = run_q & sync2_q.pll_lock;
				rdata_d[ID_LSB +: 8] = CHIP_ID;
			end
		end
	end

	always_ff @(posedge clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			route_q <= ROUTE_RST;
			en_q <= GATE_RST;
			run_q <= 1'b0;
			srst_q <= 1'b0;
			reg_rdata_o <= '0;
		end else begin
			route_q <= route_d;
			en_q <= en_d;
			run_q <= run_d;
			srst_q <= srst_d;
			reg_rdata_o <= rdata_d;
		end
	end

	// Source selection and edges for both dividers
	logic mst_now, mst_rise, pix_now, pix_rise;

	always_comb begin
		mst_now = src_lvl(route_q.mst_sel, route_q.mst_pll, sync2_q);
		mst_rise = mst_now
			& ~src_lvl(route_q.mst_sel, route_q.mst_pll, sync3_q);
		pix_now = src_lvl(route_q.pix_sel, route_q.pix_pll, sync2_q);
		pix_rise = pix_now
			& ~src_lvl(route_q.pix_sel, route_q.pix_pll, sync3_q);
	end

	clk_div_stage #(
		.W(DIV_W)
	) u_mst_div (
		.clk_i(clk_i),
		.sys_rst_i(sys_rst_i),
		.src_i(mst_now),
		.rise_i(mst_rise),
		.setup_i(route_q.mst_div),
		.clk_o(master_clk_o)
	);

	clk_div_stage #(
		.W(DIV_W)
	) u_pix_div (
		.clk_i(clk_i),
		.sys_rst_i(sys_rst_i),
		.src_i(pix_now),
		.rise_i(pix_rise),
		.setup_i(route_q.pix_div),
		.clk_o(pixel_clk_o)
	);

	// Module clock gates
	logic [GATE_N-1:0] gsrc, gen_q, gen_d, gate_d;

	// Enable moves only in a low phase, so no runt pulse escapes
	always_comb begin
		for (int i = 0; i < GATE_N; i++) begin
			gsrc[i] = master_clk_o;
		end
		gsrc[VIF_BIT] = route_q.vif_scaler ? sync2_q.scaler
			: master_clk_o;
		gsrc[SERBUS_BIT] = sync2_q.host;
		gsrc[GFX_BIT] = pixel_clk_o;
		for (int i = 0; i < GATE_N; i++) begin
			gen_d[i] = gsrc[i] ? gen_q[i] : en_q[i];
			gate_d[i] = gen_q[i] & gsrc[i];
		end
	end

	always_ff @(posedge clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			gen_q <= GATE_RST;
			gate_clk_o <= '0;
		end else begin
			gen_q <= gen_d;
			gate_clk_o <= gate_d;
		end
	end

	// Crystal watchdog, core reset and PLL control
	logic [XWD_W-1:0] xwd_q, xwd_d;
	logic rst_d, pd_d, ref_d;

	// Without crystal edges the rest of the chip never leaves reset
	always_comb begin
		if (sync2_q.xtal ^ sync3_q.xtal) begin
			xwd_d = '0;
		end else if (xwd_q >= XWD_MAX) begin
			xwd_d = XWD_MAX;
		end else begin
			xwd_d = xwd_q + XWD_W'(1);
		end
		rst_d = ~sync2_q.ext_rst_n | srst_q | (xwd_q >= XWD_MAX);
		pd_d = ~run_q;
		ref_d = src_lvl(route_q.mst_sel, 1'b0, sync2_q);
	end

	always_ff @(posedge clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			xwd_q <= XWD_MAX; // Crystal counts as dead until it toggles
			core_rst_o <= 1'b1;
			pll_powerdown_o <= 1'b1;
			pll_ref_o <= 1'b0;
		end else begin
			xwd_q <= xwd_d;
			core_rst_o <= rst_d;
			pll_powerdown_o <= pd_d;
			pll_ref_o <= ref_d;
		end
	end

	gate_closed_a: assert property ($past(sys_rst_i) |->
		gate_clk_o == '0 ##1 gate_clk_o == '0)
		else $error("gate open right after reset");
	// A closing gate may finish its high phase, so watch the held enable
	gate_quiet_a: assert property (gen_q == '0 |=>
		gate_clk_o == '0)
		else $error("gate output toggles while disabled");
	gate_no_runt_a: assert property (
		((gen_q ^ $past(gen_q)) & $past(gsrc)) == '0)
		else $error("gate enable moved in a high phase");
	vif_scaler_a: assert property ($past(route_q.vif_scaler)
		&& gate_clk_o[VIF_BIT] |-> $past(sync2_q.scaler))
		else $error("video gate not fed by scaler clock");
	grst_read_a: assert property ($past(reg_rd_i)
		&& $past(reg_addr_i) == GATE_ADDR |-> !reg_rdata_o[GRST_BIT])
		else $error("global reset bit reads one");
	sw_rst_a: assert property (srst_q |=> core_rst_o)
		else $error("software reset not applied");
	lock_ro_a: assert property (!run_q [*2] ##0 $past(reg_rd_i)
		|-> !reg_rdata_o[LOCK_BIT])
		else $error("lock bit set with PLL stopped");
	xtal_dead_a: assert property (xwd_q >= XWD_MAX |=> core_rst_o)
		else $error("reset released without crystal");
	ext_rst_a: assert property (!sync2_q.ext_rst_n |=> core_rst_o)
		else $error("external reset not passed on");
	pll_pd_a: assert property (!run_q |=> pll_powerdown_o)
		else $error("PLL not powered down");

	srst_c: cover property ($rose(srst_q) && run_q);
	gate_c: cover property ($rose(gate_clk_o[0]));
	rst_rel_c: cover property ($fell(core_rst_o));

endmodule

// [hdl/clock_unit_pkg.sv]
package clock_unit_pkg;

	// Register byte addresses
	localparam logic [7:0] ROUTE_ADDR = 8'h00;
	localparam logic [7:0] GATE_ADDR = 8'h04;

	// Gating register layout
	localparam int GATE_N = 11;
	localparam int RUN_BIT = 11;
	localparam int LOCK_BIT = 14;
	localparam int GRST_BIT = 15;
	localparam int ID_LSB = 24;
	// Chip identity, value is arbitrary
	localparam logic [7:0] CHIP_ID = 8'h5A;

	// Gate outputs with a source other than the master clock
	localparam int VIF_BIT = 5;
	localparam int SERBUS_BIT = 8;
	localparam int GFX_BIT = 10;

	// Divider setup field width
	localparam int DIV_W = 4;

	// Cycles without a crystal edge before the crystal counts as dead
	localparam int XTAL_TO = 64;
	localparam int XWD_W = 16;

	// Selectable master and pixel clock inputs
	typedef enum logic [1:0] {
		SRC_XTAL,
		SRC_PIXIN,
		SRC_HOST,
		SRC_AUX
	} clk_src_t;

	// Routing register, bit 0 is mst_sel[0]
	typedef struct packed {
		logic vif_scaler;
		logic [DIV_W-1:0] pix_div;
		logic pix_pll;
		clk_src_t pix_sel;
		logic [DIV_W-1:0] mst_div;
		logic mst_pll;
		clk_src_t mst_sel;
	} routing_t;

	localparam int ROUTE_W = $bits(routing_t);
	localparam routing_t ROUTE_RST = '0;
	localparam logic [GATE_N-1:0] GATE_RST = '0;

	// Asynchronous pin levels, all passed through two flops
	typedef struct packed {
		logic pll_lock;
		logic pll_clk;
		logic ext_rst_n;
		logic scaler;
		logic aux;
		logic host;
		logic pixin;
		logic xtal;
	} pins_t;

endpackage

// [verification/tb.sv]
`timescale 1ns/10ps
module tb;
	import clock_unit_pkg::*;
	logic clk_i = 0, sys_rst_i = 1, reg_wr_i = 0, reg_rd_i = 0;
	logic [7:0] reg_addr_i = 8'h00, cyc = 8'h00;
	logic [31:0] reg_wdata_i = 32'h0, reg_rdata_o, d;
	logic xtal = 0, pixin = 0, host = 0, aux = 0, ext_n = 1;
	logic pclk = 0, plock = 0, xon = 0, scl = 0;
	logic pref, ppd, mclk, pxclk, crst;
	logic [GATE_N-1:0] gclk;
	int fail_count = 0, n_tests = 0, tg, hi, n;
	int tab[4] = '{64, 8, 32, 16};
	// Lock-up wait scaled far down to keep the run short
	localparam int LOCK_WAIT = 32;

	clock_unit_gating_divider #(.XTAL_TIMEOUT(8)) dut (
		.clk_i(clk_i), .sys_rst_i(sys_rst_i), .reg_addr_i(reg_addr_i),
		.reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
		.reg_rdata_o(reg_rdata_o), .crystal_input_i(xtal),
		.display_pixel_clock_input_i(pixin), .host_bus_clock_i(host),
		.aux_ref_clock_i(aux), .scaler_video_clock_i(scl),
		.external_reset_n_i(ext_n), .pll_clk_i(pclk), .pll_lock_i(plock),
		.pll_ref_o(pref), .pll_powerdown_o(ppd), .master_clk_o(mclk),
		.pixel_clk_o(pxclk), .gate_clk_o(gclk), .core_rst_o(crst));

	// Clock, half period 2 ns
	always #2 clk_i = ~clk_i;

	// Source clocks of distinct periods so each route is recognisable
	always @(posedge clk_i) begin
		cyc <= cyc + 8'h01;
		xtal <= xon & ~xtal;
		host <= cyc[1];
		pixin <= cyc[3];
		aux <= cyc[2];
		pclk <= cyc[4];
		scl <= cyc[5];
	end

	task automatic w(input int k);
		repeat (k) @(posedge clk_i);
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] v);
		@(posedge clk_i);
		reg_addr_i <= a;
		reg_wdata_i <= v;
		reg_wr_i <= 1'b1;
		@(posedge clk_i);
		reg_wr_i <= 1'b0;
	endtask

	// Read data stands only in the cycle after the strobe
	task automatic rd(input logic [7:0] a, output logic [31:0] v);
		@(posedge clk_i);
		reg_addr_i <= a;
		reg_rd_i <= 1'b1;
		@(posedge clk_i);
		reg_rd_i <= 1'b0;
		#1 v = reg_rdata_o;
	endtask

	task automatic chk(input string s, input logic [31:0] e,
			input logic [31:0] g);
		n_tests++;
		if (g !== e) begin
			fail_count++;
			$display("MISMATCH %s exp %h got %h", s, e, g);
		end
	endtask

	function automatic logic pick(input int s);
		return s < 0 ? pref : s == 0 ? mclk
			: s == 1 ? pxclk : gclk[s-2];
	endfunction

	// Window length a multiple of the period keeps counts exact
	task automatic cnt(input int s, input int len, output int t,
			output int h);
		logic p, v;
		t = 0;
		h = 0;
		@(posedge clk_i);
		#1 p = pick(s);
		repeat (len) begin
			@(posedge clk_i);
			#1 v = pick(s);
			t += int'(v !== p);
			h += int'(v === 1'b1);
			p = v;
		end
	endtask

	task automatic t_reset;
		rd(GATE_ADDR, d);
		chk("gate reg", {CHIP_ID, 24'h0}, d);
		chk("gates", 0, gclk);
		chk("pll pd", 1, ppd);
		chk("core rst", 1, crst);
	endtask

	task automatic t_regs;
		xon = 1;
		w(20);
		chk("core rst", 0, crst);
		wr(GATE_ADDR, 32'h8800);
		w(3);
		chk("core rst", 1, crst);
		chk("pll pd", 0, ppd);
		rd(GATE_ADDR, d);
		chk("gate reg", {CHIP_ID, 24'h000800}, d);
		wr(GATE_ADDR, 32'h4800);
		rd(GATE_ADDR, d);
		chk("gate reg", {CHIP_ID, 24'h000800}, d);
		// PLL model locks after the fixed wait, not after a poll
		w(LOCK_WAIT);
		plock <= 1'b1;
		w(4);
		rd(GATE_ADDR, d);
		chk("gate reg", {CHIP_ID, 24'h004800}, d);
		chk("core rst", 0, crst);
		wr(8'h08, 32'hFFFFFFFF);
		rd(8'h08, d);
		chk("unmapped", 0, d);
		rd(ROUTE_ADDR, d);
		chk("route reg", 0, d);
		w(1);
		ext_n <= 1'b0;
		w(4);
		chk("core rst", 1, crst);
		ext_n <= 1'b1;
		w(6);
		chk("core rst", 0, crst);
	endtask

	task automatic t_div;
		for (int s = 0; s < 7; s++) begin
			wr(ROUTE_ADDR, 32'(s) << 3);
			w(12);
			cnt(0, 840, tg, hi);
			n = s + 1;
			chk("div edges", 840 / n, tg);
			chk("div high", n == 1 ? 420 : 840 / n * (n / 2), hi);
		end
	endtask

	task automatic t_src;
		for (int s = 0; s < 4; s++) begin
			wr(ROUTE_ADDR, 32'(s) | (32'(s) << 7));
			w(20);
			cnt(0, 64, tg, hi);
			chk("master src", tab[s], tg);
			cnt(1, 64, tg, hi);
			chk("pixel src", tab[s], tg);
			cnt(-1, 64, tg, hi);
			chk("pll ref", tab[s], tg);
		end
		wr(ROUTE_ADDR, 32'h204);
		w(40);
		cnt(-1, 64, tg, hi);
		chk("pll ref raw", 64, tg);
		cnt(0, 64, tg, hi);
		chk("master pll", 4, tg);
		cnt(1, 64, tg, hi);
		chk("pixel pll", 4, tg);
	endtask

	task automatic t_gate;
		wr(ROUTE_ADDR, 32'h4180);
		w(20);
		cnt(2, 64, tg, hi);
		chk("gate closed", 0, tg);
		wr(GATE_ADDR, 32'h0FFF);
		w(12);
		for (int b = 0; b < GATE_N; b++) begin
			cnt(b + 2, 64, tg, hi);
			n = b == 5 ? 2 : b == 8 ? 32 : b == 10 ? 16 : 64;
			chk("gate clock", n, tg);
		end
		wr(GATE_ADDR, 32'h0800);
		w(12);
		cnt(2, 64, tg, hi);
		chk("gate shut", 0, tg);
		xon = 0;
		w(30);
		chk("core rst", 1, crst);
	endtask

	task automatic results;
		$display("comparisons %0d mismatches %0d", n_tests, fail_count);
		if (fail_count == 0 && n_tests > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask

	// Main sequence after 12 reset cycles
	initial begin
		w(12);
		sys_rst_i <= 1'b0;
		t_reset;
		t_regs;
		t_div;
		t_src;
		t_gate;
		results;
	end

	// Watchdog, well beyond the ~8000 cycles the tests need
	initial begin
		#80000;
		fail_count++;
		results;
	end
endmodule
